// file: rtl/thf_pkg.sv
// Constants shared by the hop, turnaround and TX FIFO register bank
// Function
// - Misc bit 3 set selects the alternate amplifier sequence, else default.
// - Eight-bit read/write hop channel number, zero after reset.
// - Eight-bit read/write hop step size, counted in 10 kHz units.
// - Hop offset equals channel times step times 10 kHz.
// - Compliance bit set: packet length counts CRC bytes plus payload.
// - Compliance bit clear: length is payload only; CRC enabled separately.
// - Turnaround enable bit 2 allows frequency change at packet end.
// - Turnaround phase field picks bit position in last byte for shift.
// - Turnaround and length register resets to 0x7b.
// - Six-bit read/write almost-full threshold in bits 5:0.
// - Six-bit read/write almost-empty threshold, 0x04 after reset.
// - Serial write to FIFO data address pushes burst bytes into FIFO via a holding slot, dropping any byte that finds the slot full.
// - FIFO burst keeps the serial address fixed, no increment.
package thf_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [6:0] MISC_OFS      = 7'h78;
  localparam logic [6:0] HOP_CH_OFS    = 7'h79;
  localparam logic [6:0] HOP_STEP_OFS  = 7'h7a;
  localparam logic [6:0] TURN_OFS      = 7'h7b;
  localparam logic [6:0] FULL_THR_OFS  = 7'h7c;
  localparam logic [6:0] EMPTY_THR_OFS = 7'h7d;
  localparam logic [6:0] FIFO_OFS      = 7'h7f;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MISC_RST      = 8'h00;
  localparam logic [7:0] HOP_CH_RST    = 8'h00;
  localparam logic [7:0] HOP_STEP_RST  = 8'h00;
  localparam logic [7:0] TURN_RST      = 8'h7b;
  localparam logic [7:0] FULL_THR_RST  = 8'h37;
  localparam logic [7:0] EMPTY_THR_RST = 8'h04;

  // ==========================================================
  // Field positions
  localparam int ALT_SEQ_BIT    = 3;
  localparam int TRIM_MSB       = 2;
  localparam int LEN_CRC_BIT    = 7;
  localparam int TURN_EN_BIT    = 2;
  localparam int PHASE_MSB      = 1;
  localparam int THR_MSB        = 5;
  localparam int WRITE_CMD_BIT  = 7;

  // ==========================================================
  // Counts and scales
  localparam logic [19:0] HOP_STEP_KHZ   = 20'h0000a;
  localparam logic [7:0]  CRC_BYTES      = 8'h02;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam int          FIFO_DEPTH_DEF = 8;
  localparam int          SYNC_STAGES    = 2;

endpackage

// file: rtl/thf_stream_if.sv
// Valid/ready byte stream between the register bank and its FIFO
`timescale 1ns/10ps
interface thf_stream_if
#(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport sender
  (
    output data,
    output valid,
    input  ready
  );

  modport receiver
  (
    input  data,
    input  valid,
    output ready
  );
endinterface

// file: rtl/thf_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module thf_sync
#(
  parameter int W = 1
)
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);
  import thf_pkg::*;

  typedef struct packed
  {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } thf_sync_state_t;

  thf_sync_state_t stateReg;
  thf_sync_state_t stateNext;

  // ==========================================================
  // Stages; first stage feeds only the second
  always_comb
  begin
    stateNext        = stateReg;
    stateNext.first  = async;
    stateNext.second = stateReg.first;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  assign synced = stateReg.second;
endmodule

// file: rtl/thf_fifo.sv
// Byte FIFO with fill level, valid/ready on both sides
`timescale 1ns/10ps
module thf_fifo
#(
  parameter int W     = 8,
  parameter int DEPTH = thf_pkg::FIFO_DEPTH_DEF
)
(
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  thf_stream_if.receiver                  inS,
  thf_stream_if.sender                    outS,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  import thf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wrPtr;
    logic [PW-1:0]           rdPtr;
    logic [LW-1:0]           count;
  } thf_fifo_state_t;

  thf_fifo_state_t stateReg;
  thf_fifo_state_t stateNext;
  logic            doPush;
  logic            doPop;

  // ==========================================================
  // Honest full and empty drive the handshakes
  assign inS.ready  = (stateReg.count != LW'(DEPTH));
  assign outS.valid = (stateReg.count != '0);
  assign outS.data  = stateReg.mem[stateReg.rdPtr];
  assign doPush     = inS.valid && inS.ready;
  assign doPop      = outS.valid && outS.ready;
  assign level      = stateReg.count;

  always_comb
  begin
    stateNext = stateReg;
    if (doPush)
    begin
      stateNext.mem[stateReg.wrPtr] = inS.data;
      stateNext.wrPtr = (stateReg.wrPtr == PW'(DEPTH-1)) ? '0 : stateReg.wrPtr + 1'b1;
    end
    if (doPop)
      stateNext.rdPtr = (stateReg.rdPtr == PW'(DEPTH-1)) ? '0 : stateReg.rdPtr + 1'b1;
    if (doPush && !doPop)
      stateNext.count = stateReg.count + 1'b1;
    else if (doPop && !doPush)
      stateNext.count = stateReg.count - 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end
endmodule

// file: rtl/thf_misc_regs.sv
// Serial-port register bank: hopping, turnaround, TX FIFO thresholds and data port
`timescale 1ns/10ps
module thf_misc_regs
#(
  parameter int FIFO_DEPTH = thf_pkg::FIFO_DEPTH_DEF
)
(
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic                          sclk,
  input  wire logic                          sdi,
  input  wire logic                          selN,
  output logic                               sdo,
  output logic [7:0]                         txData,
  output logic                               txValid,
  input  wire logic                          txReady,
  output logic                               alternate_amp_sequence_en,
  output logic [thf_pkg::TRIM_MSB:0]         oscTrim,
  output logic [7:0]                         hopChannel,
  output logic [7:0]                         hopStep,
  output logic [19:0]                        hopOffsetKhz,
  input  wire logic [7:0]                    pktLength,
  input  wire logic                          crcEn,
  output logic [7:0]                         payloadLen,
  input  wire logic                          lastByte,
  input  wire logic [2:0]                    txBitIdx,
  output logic                               freqShiftPulse,
  output logic                               fifoAlmostFull,
  output logic                               fifoAlmostEmpty,
  output logic [$clog2(FIFO_DEPTH+1)-1:0]    fifoLevel,
  output logic                               writeDropped
);
  import thf_pkg::*;

  typedef struct packed
  {
    logic       sclkLast;
    logic [3:0] bitCnt;
    logic       dataPhase;
    logic       isWrite;
    logic [6:0] addr;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic       sdo;
    logic [7:0] misc;
    logic [7:0] hopCh;
    logic [7:0] hopStep;
    logic [7:0] turn;
    logic [7:0] fullThr;
    logic [7:0] emptyThr;
    logic [7:0] pendByte;
    logic       pendValid;
    logic       dropped;
    logic [7:0] payloadLen;
    logic [19:0] hopOffset;
    logic       shiftCond;
    logic       shiftPulse;
    logic       almostFull;
    logic       almostEmpty;
  } thf_regs_state_t;

  thf_regs_state_t stateReg;
  thf_regs_state_t stateNext;

  logic [2:0] pinSync;
  logic       sclkS;
  logic       sdiS;
  logic       selS;
  logic [7:0] rxByte;
  logic       sclkRise;
  logic       sclkFall;
  logic       byteDone;
  logic [6:0] nextAddr;
  logic [7:0] levelWide;

  thf_stream_if #(.W(8)) pushS ();
  thf_stream_if #(.W(8)) drainS ();

  // ==========================================================
  // Pin synchronisers
  thf_sync #(.W(3)) pinSyncI
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async    ({sclk, sdi, selN}),
    .synced   (pinSync)
  );

  assign sclkS = pinSync[2];
  assign sdiS  = pinSync[1];
  assign selS  = pinSync[0];

  // ==========================================================
  // Transmit FIFO; byte waits in a holding slot while full
  thf_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) txFifoI
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .inS      (pushS.receiver),
    .outS     (drainS.sender),
    .level    (fifoLevel)
  );

  assign pushS.data   = stateReg.pendByte;
  assign pushS.valid  = stateReg.pendValid;
  assign txData       = drainS.data;
  assign txValid      = drainS.valid;
  assign drainS.ready = txReady;
  assign levelWide    = 8'(fifoLevel);

  // ==========================================================
  // Serial framing helpers
  assign sclkRise = !selS && sclkS && !stateReg.sclkLast;
  assign sclkFall = !selS && !sclkS && stateReg.sclkLast;
  assign rxByte   = {stateReg.shiftIn[6:0], sdiS};
  assign byteDone = sclkRise && (stateReg.bitCnt == BITS_PER_BYTE - 4'h1);

  assign nextAddr = (stateReg.addr == FIFO_OFS) ? stateReg.addr : stateReg.addr + 7'h01;

  // Read mux; unmapped and FIFO port read as zero
  function automatic logic [7:0] readReg(input thf_regs_state_t s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      MISC_OFS:
        v = s.misc;
      HOP_CH_OFS:
        v = s.hopCh;
      HOP_STEP_OFS:
        v = s.hopStep;
      TURN_OFS:
        v = s.turn;
      FULL_THR_OFS:
        v = s.fullThr;
      EMPTY_THR_OFS:
        v = s.emptyThr;
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    stateNext          = stateReg;
    stateNext.sclkLast = sclkS;
    stateNext.dropped  = 1'b0;

    // Holding slot drains into the FIFO when it has room
    if (stateReg.pendValid && pushS.ready)
      stateNext.pendValid = 1'b0;

    if (selS)
    begin
      stateNext.bitCnt    = 4'h0;
      stateNext.dataPhase = 1'b0;
      // Idle low so a deselected line reads zero
      stateNext.sdo       = 1'b0;
    end
    else if (sclkRise)
    begin
      stateNext.shiftIn = rxByte;
      stateNext.bitCnt  = byteDone ? 4'h0 : stateReg.bitCnt + 4'h1;
    end
    else if (sclkFall && stateReg.dataPhase && !stateReg.isWrite)
    begin
      stateNext.sdo      = stateReg.shiftOut[7];
      stateNext.shiftOut = {stateReg.shiftOut[6:0], 1'b0};
    end

    if (byteDone && !stateReg.dataPhase)
    begin
      stateNext.dataPhase = 1'b1;
      stateNext.isWrite   = rxByte[WRITE_CMD_BIT];
      stateNext.addr      = rxByte[6:0];
      stateNext.shiftOut  = readReg(stateReg, rxByte[6:0]);
    end
    else if (byteDone)
    begin
      stateNext.addr     = nextAddr;
      stateNext.shiftOut = readReg(stateReg, nextAddr);
      if (stateReg.isWrite)
      begin
        case (stateReg.addr)
          MISC_OFS:
          begin
            stateNext.misc = rxByte;
          end
          HOP_CH_OFS:
          begin
            stateNext.hopCh = rxByte;
          end
          HOP_STEP_OFS:
          begin
            stateNext.hopStep = rxByte;
          end
          TURN_OFS:
          begin
            stateNext.turn = rxByte;
          end
          FULL_THR_OFS:
          begin
            stateNext.fullThr = rxByte;
          end
          EMPTY_THR_OFS:
          begin
            stateNext.emptyThr = rxByte;
          end
          FIFO_OFS:
          begin
            if (stateNext.pendValid)
              stateNext.dropped = 1'b1;
            else
            begin
              stateNext.pendByte  = rxByte;
              stateNext.pendValid = 1'b1;
            end
          end
          default:       stateNext.dropped = stateReg.dropped;
        endcase
      end
    end

    stateNext.hopOffset = 20'(20'(stateReg.hopCh) * 20'(stateReg.hopStep) * HOP_STEP_KHZ);

    if (stateReg.turn[LEN_CRC_BIT] && crcEn)
      stateNext.payloadLen = (pktLength > CRC_BYTES) ? pktLength - CRC_BYTES : 8'h00;
    else
      stateNext.payloadLen = pktLength;

    // Shift at phase-selected bit of last byte
    stateNext.shiftCond  = stateReg.turn[TURN_EN_BIT] && lastByte
                           && (txBitIdx == {1'b1, stateReg.turn[PHASE_MSB:0]});
    stateNext.shiftPulse = stateNext.shiftCond && !stateReg.shiftCond;

    stateNext.almostFull  = levelWide >= {2'b00, stateReg.fullThr[THR_MSB:0]};
    stateNext.almostEmpty = levelWide <= {2'b00, stateReg.emptyThr[THR_MSB:0]};
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateReg.sclkLast    <= 1'b0;
      stateReg.bitCnt      <= 4'h0;
      stateReg.dataPhase   <= 1'b0;
      stateReg.isWrite     <= 1'b0;
      stateReg.addr        <= 7'h00;
      stateReg.shiftIn     <= 8'h00;
      stateReg.shiftOut    <= 8'h00;
      stateReg.sdo         <= 1'b0;
      stateReg.misc        <= MISC_RST;
      stateReg.hopCh       <= HOP_CH_RST;
      stateReg.hopStep     <= HOP_STEP_RST;
      stateReg.turn        <= TURN_RST;
      stateReg.fullThr     <= FULL_THR_RST;
      stateReg.emptyThr    <= EMPTY_THR_RST;
      stateReg.pendByte    <= 8'h00;
      stateReg.pendValid   <= 1'b0;
      stateReg.dropped     <= 1'b0;
      stateReg.payloadLen  <= 8'h00;
      stateReg.hopOffset   <= 20'h00000;
      stateReg.shiftCond   <= 1'b0;
      stateReg.shiftPulse  <= 1'b0;
      stateReg.almostFull  <= 1'b0;
      stateReg.almostEmpty <= 1'b1;
    end
    else
      stateReg <= stateNext;
  end

  // ==========================================================
  // Outputs
  // Sequence select to amplifier control
  assign alternate_amp_sequence_en = stateReg.misc[ALT_SEQ_BIT];
  assign oscTrim         = stateReg.misc[TRIM_MSB:0];
  assign hopChannel      = stateReg.hopCh;
  assign hopStep         = stateReg.hopStep;
  assign hopOffsetKhz    = stateReg.hopOffset;
  assign payloadLen      = stateReg.payloadLen;
  assign freqShiftPulse  = stateReg.shiftPulse;
  assign fifoAlmostFull  = stateReg.almostFull;
  assign fifoAlmostEmpty = stateReg.almostEmpty;
  assign writeDropped    = stateReg.dropped;
  assign sdo             = stateReg.sdo;
endmodule

// file: test/thf_misc_regs_props.sv
// Assertion checker on the register bank top ports
`timescale 1ns/10ps
module thf_misc_regs_props
#(
  parameter int FIFO_DEPTH = thf_pkg::FIFO_DEPTH_DEF
)
(
  input wire logic                            core_clk,
  input wire logic                            arst_n,
  input wire logic                            sclk,
  input wire logic                            sdi,
  input wire logic                            selN,
  input wire logic                            sdo,
  input wire logic [7:0]                      txData,
  input wire logic                            txValid,
  input wire logic                            txReady,
  input wire logic                            alternate_amp_sequence_en,
  input wire logic [thf_pkg::TRIM_MSB:0]      oscTrim,
  input wire logic [7:0]                      hopChannel,
  input wire logic [7:0]                      hopStep,
  input wire logic [19:0]                     hopOffsetKhz,
  input wire logic [7:0]                      pktLength,
  input wire logic                            crcEn,
  input wire logic [7:0]                      payloadLen,
  input wire logic                            lastByte,
  input wire logic [2:0]                      txBitIdx,
  input wire logic                            freqShiftPulse,
  input wire logic                            fifoAlmostFull,
  input wire logic                            fifoAlmostEmpty,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifoLevel,
  input wire logic                            writeDropped
);
  import thf_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================
  // Sequences
  sequence s_pop;
    txValid && txReady;
  endsequence
  sequence s_empty2;
    (fifoLevel == 0) [*2];
  endsequence

  // ==========================================
  // Checks
  // upper bit positions
  a_shift_cause: assert property (
    freqShiftPulse |-> $past(lastByte) && $past(txBitIdx[2]))
    else $error("shift pulse without last byte cause");
  a_shift_once: assert property (
    freqShiftPulse |=> !freqShiftPulse) else $error("shift pulse too long");
  a_hop_product: assert property (
    hopOffsetKhz == 20'($past(hopChannel)) * 20'($past(hopStep)) * HOP_STEP_KHZ)
    else $error("hop offset wrong");
  a_payload_raw: assert property (
    !crcEn |=> payloadLen == $past(pktLength)) else $error("payload length altered");
  a_payload_crc: assert property (
    crcEn |=> payloadLen <= $past(pktLength)) else $error("payload exceeds length");
  a_valid_level: assert property (
    txValid == (fifoLevel != 0)) else $error("valid disagrees with level");
  a_pop_shrink: assert property (
    s_pop |=> fifoLevel <= $past(fifoLevel)) else $error("level grew on pop");
  a_empty_flag: assert property (
    s_empty2 |-> fifoAlmostEmpty) else $error("almost empty missing");
  a_drop_full: assert property (
    writeDropped |-> $past(fifoLevel) == FIFO_DEPTH) else $error("drop while not full");
endmodule

// file: test/thf_host.sv
// Host microcontroller model on the four-wire serial port
`timescale 1ns/10ps
module thf_host
(
  input  wire logic core_clk,
  output logic      sclk,
  output logic      sdi,
  output logic      selN,
  input  wire logic sdo
);
  logic [7:0] rxQ[$];

  // Clock stands low between frames
  initial
  begin
    sclk = 1'b0;
    sdi  = 1'b1;
    selN = 1'b1;
  end

  // Half of a 160 ns serial period
  task automatic half();
    repeat (16) @(posedge core_clk);
  endtask

  // MSB first; sdo taken at each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi <= tx[i];
      half();
      sclk  <= 1'b1;
      rx[i] = sdo;
      half();
      sclk <= 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input logic [7:0] d[$]);
    logic [7:0] r;
    rxQ = {};
    selN <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer(cmd, r);
    foreach (d[i])
    begin
      xfer(d[i], r);
      rxQ.push_back(r);
    end
    repeat (8) @(posedge core_clk);
    selN <= 1'b1;
    // Released line shows no stale value
    sdi <= ~sdi;
    half();
  endtask
endmodule

// file: test/tx_hop_fifo_misc_regs_test.sv
// Serial-port tests of the hop, turnaround and TX FIFO register bank
`timescale 1ns/10ps
module tx_hop_fifo_misc_regs_test;
  import thf_pkg::*;
  localparam int FIFO_DEPTH = 8;
  logic                            core_clk, arst_n, sclk, sdi, selN, sdo;
  logic                            txValid, txReady, crcEn, lastByte, alternate_amp_sequence_en;
  logic                            freqShiftPulse, fifoAlmostFull, fifoAlmostEmpty, writeDropped;
  logic [7:0]                      txData, hopChannel, hopStep, pktLength, payloadLen;
  logic [2:0]                      oscTrim, txBitIdx;
  logic [19:0]                     hopOffsetKhz;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifoLevel;
  int                              badCount = 0, cmpCount = 0, pulses = 0, drops = 0;
  logic [7:0]                      rstVals[$] = {MISC_RST, HOP_CH_RST, HOP_STEP_RST,
                                                 TURN_RST, FULL_THR_RST, EMPTY_THR_RST};
  logic [7:0]                      cfg[$] = {8'h08, 8'h05, 8'h0c, 8'h86, 8'h06, 8'h02};
  logic [7:0]                      fb[$] = {8'h01, 8'h80, 8'hff, 8'h00, 8'h5a,
                                            8'ha5, 8'h3c, 8'hc3, 8'h7e, 8'he7};

  thf_misc_regs #(.FIFO_DEPTH(FIFO_DEPTH)) u_thf_misc_regs (.*);
  thf_host u_thf_host (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (freqShiftPulse === 1'b1)
      pulses <= pulses + 1;
    if (writeDropped === 1'b1)
      drops <= drops + 1;
  end

  // ==========================================
  // Tasks
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic reportAndStop();
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
    u_thf_host.frame({1'b1, a}, d);
  endtask

  task automatic rdChk(input logic [6:0] a, input logic [7:0] e[$]);
    logic [7:0] z[$];
    foreach (e[i])
      z.push_back(8'h00);
    u_thf_host.frame({1'b0, a}, z);
    foreach (e[i])
      chk("readback", e[i], u_thf_host.rxQ[i]);
  endtask

  task automatic pay(input logic c, input logic [7:0] p, input logic [7:0] e);
    crcEn     <= c;
    pktLength <= p;
    repeat (3) @(posedge core_clk);
    chk("payloadLen", e, payloadLen);
  endtask

  task automatic shift(input logic [2:0] idx, input int e);
    int p0;
    p0 = pulses;
    lastByte <= 1'b1;
    txBitIdx <= idx;
    repeat (6) @(posedge core_clk);
    lastByte <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("shift pulses", 20'(e), 20'(pulses - p0));
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    int n;
    arst_n    = 1'b0;
    txReady   = 1'b0;
    crcEn     = 1'b0;
    lastByte  = 1'b0;
    pktLength = 8'h00;
    txBitIdx  = 3'h0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdChk(MISC_OFS, rstVals);
    rdChk(7'h7e, {8'h00, 8'h00});
    // Trim left at default
    wr(MISC_OFS, cfg);
    rdChk(MISC_OFS, cfg);
    chk("alt", 1'b1, alternate_amp_sequence_en);
    chk("trim", 3'h0, oscTrim);
    chk("hop", 20'h00258, hopOffsetKhz);
    chk("hopChannel", 20'h00005, 20'(hopChannel));
    chk("hopStep", 20'h0000c, 20'(hopStep));
    pay(1'b1, 8'h09, 8'h07);
    pay(1'b0, 8'h09, 8'h09);
    pay(1'b1, 8'h01, 8'h00);
    shift(3'h6, 1);
    shift(3'h5, 0);
    wr(TURN_OFS, {8'h02});
    shift(3'h6, 0);
    pay(1'b1, 8'h09, 8'h09);
    // Drain side stalls while ten bytes arrive
    wr(FIFO_OFS, fb);
    chk("level", 20'(FIFO_DEPTH), 20'(fifoLevel));
    chk("afull", 1'b1, fifoAlmostFull);
    chk("aempty", 1'b0, fifoAlmostEmpty);
    chk("drops", 20'h00001, 20'(drops));
    for (int i = 0; i < 9; i++)
    begin
      n = 0;
      while (txValid !== 1'b1 && n < 50)
      begin
        @(posedge core_clk);
        n++;
      end
      if (n == 50)
      begin
        badCount++;
        reportAndStop();
      end
      chk("txData", fb[i], txData);
      txReady <= 1'b1;
      @(posedge core_clk);
      txReady <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    chk("level", 20'h00000, 20'(fifoLevel));
    chk("aempty", 1'b1, fifoAlmostEmpty);
    reportAndStop();
  end
endmodule

bind thf_misc_regs thf_misc_regs_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_thf_misc_regs_props (.*);
